/* src/pcg_map.svh */
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH
// ---------------------------------------------------------------------------
// register word addresses
// ---------------------------------------------------------------------------
`define PCG_CH_STRIDE 7'h08
`define PCG_OFS_VSTART 3'h0
`define PCG_OFS_VDUR 3'h1
`define PCG_OFS_HSTART 3'h2
`define PCG_OFS_HDUR 3'h3
`define PCG_OFS_CTRL 3'h4
`define PCG_ADDR_OUT_FMT 7'h50
`define PCG_ADDR_IN_FMT 7'h51
`define PCG_ADDR_LINE 7'h52
`define PCG_ADDR_PIXEL 7'h53
// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define PCG_CTRL_POL_BIT 0
`define PCG_CTRL_TOG_BIT 1
`define PCG_OUT_FMT_INV_EN_BIT 3
`define PCG_OUT_FMT_INV_SENSE_BIT 4
`define PCG_IN_FMT_BLANK_EN_BIT 6
// ---------------------------------------------------------------------------
// reset values, timing counts and channel numbers
// ---------------------------------------------------------------------------
`define PCG_RST_TIMING 16'h0000
`define PCG_RST_CTRL 8'h00
`define PCG_RST_FMT 8'h00
`define PCG_DATA_LEAD 4
`define PCG_INV_CHANNEL 0
`define PCG_BLANK_CHANNEL 9
`endif

/* src/pcg_pkg.sv */
package pcg_pkg;
  typedef logic [15:0] pcg_word_t;
  typedef logic [7:0] pcg_ctrl_t;
  typedef enum logic [2:0] {
    PCG_F_VSTART,
    PCG_F_VDUR,
    PCG_F_HSTART,
    PCG_F_HDUR,
    PCG_F_CTRL
  } pcg_field_t;
endpackage : pcg_pkg

/* src/pcg_pulse_gen.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pcg_map.svh"

// Summary of operation
// R1: vertical component enabled from vertical start line for vertical duration lines.
// R2: horizontal component asserted at horizontal start pixel for horizontal duration pixels.
// R3: horizontal pulses only on lines where vertical component is enabled.
// R4: all four timing values zero gives constant output equal to polarity bit 0.
// R5: vertical values zero, horizontal nonzero: pulse on every line.
// R6: horizontal duration zero: one multi-line pulse from start line/pixel to start+duration.
// R7: all values nonzero: one pulse per line within the line band.
// R8: polarity bit one makes pulses active low, zero active high.
// R9: control bit 1 selects toggle mode, otherwise toggling is off.
// R10: toggle mode inverts the output on each rising edge of the pulse.
// R11: software programs an odd number of toggle edges per frame.
// R12: software keeps horizontal duration nonzero in toggle mode.
// R13: pixel count starts four clocks before first pixel data leaves.
// R14: output format bit 3 lets channel 0 invert outgoing colour data.
// R15: input format bit 6 lets channel 9 blank data, lane clock and start pulse.
// R16: pixel counter runs at the pixel clock and covers at least 2048 counts.
// R17: ten identical channels, each with its own five registers.
// R18: pixel count restarts each line, line count each frame, first line is one.
module pcg_pulse_gen #(
  parameter int CHANNELS = 10,
  parameter int CNT_W = 12,
  parameter int DATA_W = 18
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // video timing and data pins
  input wire logic line_start_pin,
  input wire logic frame_start_pin,
  input wire logic [DATA_W-1:0] pixel_data_pin,
  // panel driver side
  output logic [CHANNELS-1:0] programmable_control_output,
  output logic [DATA_W-1:0] colour_data_out,
  output logic serial_lane_clock_en,
  output logic column_start_pulse
);

  // ---------------------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------------------
  generate
    if (CNT_W < 12 || CNT_W > 16) begin : gen_bad_cnt_w
      // below 12 bits a line cannot reach 2048 counts; above 16 the register port cannot hold it
      $error("pcg_pulse_gen: CNT_W must be 12..16");
    end
    if (CHANNELS != 10) begin : gen_bad_channels
      // the map gives eight words per channel and puts the format registers right after ten of them
      $error("pcg_pulse_gen: ten channels expected");
    end
    if (DATA_W < 1) begin : gen_bad_data_w
      $error("pcg_pulse_gen: DATA_W must be positive");
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic line_meta;
  logic line_sync;
  logic line_prev;
  logic frame_meta;
  logic frame_sync;
  logic frame_prev;
  logic [DATA_W-1:0] data_meta;
  logic [DATA_W-1:0] data_sync;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      line_meta <= 1'b0;
      line_sync <= 1'b0;
      line_prev <= 1'b0;
      frame_meta <= 1'b0;
      frame_sync <= 1'b0;
      frame_prev <= 1'b0;
    end else begin
      line_meta <= line_start_pin;
      line_sync <= line_meta;
      line_prev <= line_sync;
      frame_meta <= frame_start_pin;
      frame_sync <= frame_meta;
      frame_prev <= frame_sync;
    end
  end

  // data is never reset: it flows to colour_data_out whether or not a line has started
  always_ff @(posedge clk_sys) begin
    data_meta <= pixel_data_pin;
    data_sync <= data_meta;
  end

  logic line_edge;
  logic frame_edge;
  assign line_edge = line_sync & ~line_prev;
  assign frame_edge = frame_sync & ~frame_prev;

  // ---------------------------------------------------------------------------
  // line and pixel counters
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0] pix_cnt;
  logic [CNT_W-1:0] line_cnt;
  logic line_seen;

  // pixel count saturates rather than wrap, so a missing line strobe
  // cannot fire channels a second time in the same line
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pix_cnt <= '0;
    end else if (line_edge) begin
      pix_cnt <= CNT_W'(1); // R18
    end else if (line_seen && pix_cnt != '1) begin
      pix_cnt <= pix_cnt + CNT_W'(1); // R16
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      line_cnt <= '0;
      line_seen <= 1'b0;
    end else if (line_edge) begin
      line_seen <= 1'b1;
      if (frame_edge || frame_sync) begin
        line_cnt <= CNT_W'(1); // R18
      end else if (line_cnt != '1) begin
        line_cnt <= line_cnt + CNT_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0] vstart [CHANNELS];
  logic [CNT_W-1:0] vdur [CHANNELS];
  logic [CNT_W-1:0] hstart [CHANNELS];
  logic [CNT_W-1:0] hdur [CHANNELS];
  pcg_pkg::pcg_ctrl_t ctrl [CHANNELS];
  pcg_pkg::pcg_ctrl_t out_fmt;
  pcg_pkg::pcg_ctrl_t in_fmt;

  logic [3:0] acc_ch;
  logic [2:0] acc_fld;
  logic acc_in_ch;
  assign acc_ch = reg_addr[6:3];
  assign acc_fld = reg_addr[2:0];
  assign acc_in_ch = reg_addr < 7'(CHANNELS * 8);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        vstart[i] <= CNT_W'(`PCG_RST_TIMING);
        vdur[i] <= CNT_W'(`PCG_RST_TIMING);
        hstart[i] <= CNT_W'(`PCG_RST_TIMING);
        hdur[i] <= CNT_W'(`PCG_RST_TIMING);
        ctrl[i] <= `PCG_RST_CTRL;
      end
    end else if (reg_wr && acc_in_ch) begin
      case (acc_fld)
        `PCG_OFS_VSTART: vstart[acc_ch] <= reg_wdata[CNT_W-1:0];
        `PCG_OFS_VDUR: vdur[acc_ch] <= reg_wdata[CNT_W-1:0];
        `PCG_OFS_HSTART: hstart[acc_ch] <= reg_wdata[CNT_W-1:0];
        `PCG_OFS_HDUR: hdur[acc_ch] <= reg_wdata[CNT_W-1:0];
        `PCG_OFS_CTRL: ctrl[acc_ch] <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_fmt <= `PCG_RST_FMT;
      in_fmt <= `PCG_RST_FMT;
    end else if (reg_wr) begin
      if (reg_addr == `PCG_ADDR_OUT_FMT) begin
        out_fmt <= reg_wdata[7:0];
      end
      if (reg_addr == `PCG_ADDR_IN_FMT) begin
        in_fmt <= reg_wdata[7:0];
      end
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      if (acc_in_ch) begin
        case (acc_fld)
          `PCG_OFS_VSTART: reg_rdata <= 16'(vstart[acc_ch]);
          `PCG_OFS_VDUR: reg_rdata <= 16'(vdur[acc_ch]);
          `PCG_OFS_HSTART: reg_rdata <= 16'(hstart[acc_ch]);
          `PCG_OFS_HDUR: reg_rdata <= 16'(hdur[acc_ch]);
          `PCG_OFS_CTRL: reg_rdata <= 16'(ctrl[acc_ch]);
          default: reg_rdata <= '0;
        endcase
      end else if (reg_addr == `PCG_ADDR_OUT_FMT) begin
        reg_rdata <= 16'(out_fmt);
      end else if (reg_addr == `PCG_ADDR_IN_FMT) begin
        reg_rdata <= 16'(in_fmt);
      end else if (reg_addr == `PCG_ADDR_LINE) begin
        reg_rdata <= 16'(line_cnt);
      end else if (reg_addr == `PCG_ADDR_PIXEL) begin
        reg_rdata <= 16'(pix_cnt);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------------------
  logic [CHANNELS-1:0] raw_q;
  logic [CHANNELS-1:0] tog_q;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gen_ch // R17
      logic [CNT_W:0] v_end;
      logic [CNT_W:0] h_end;
      logic v_zero;
      logic h_zero;
      logic all_zero;
      logic v_en;
      logic h_on;
      logic band_on;
      logic next_raw;
      // the ends carry one extra bit so start plus duration cannot wrap to a small count
      assign v_end = {1'b0, vstart[g]} + {1'b0, vdur[g]};
      assign h_end = {1'b0, hstart[g]} + {1'b0, hdur[g]};
      assign v_zero = vstart[g] == '0 && vdur[g] == '0;
      assign h_zero = hstart[g] == '0 && hdur[g] == '0;
      assign all_zero = v_zero && h_zero;
      // line band; with both vertical values zero every line is in band
      assign v_en = v_zero || ({1'b0, line_cnt} >= {1'b0, vstart[g]} && {1'b0, line_cnt} < v_end); // R1 R5
      assign h_on = {1'b0, pix_cnt} >= {1'b0, hstart[g]} && {1'b0, pix_cnt} < h_end; // R2
      // multi-line span from (start line, start pixel) to (end line, start pixel)
      assign band_on = ({1'b0, line_cnt} > {1'b0, vstart[g]} ||
                        (line_cnt == vstart[g] && pix_cnt >= hstart[g])) &&
                       ({1'b0, line_cnt} < v_end ||
                        ({1'b0, line_cnt} == v_end && pix_cnt < hstart[g])); // R6
      always_comb begin
        if (all_zero || !line_seen) begin
          next_raw = 1'b0; // R4
        end else if (hdur[g] == '0 && !v_zero) begin
          next_raw = band_on; // R6
        end else begin
          next_raw = v_en && h_on; // R3 R7
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          raw_q[g] <= 1'b0;
        end else begin
          raw_q[g] <= next_raw;
        end
      end

      // toggle state holds across frames so odd edge counts alternate polarity
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          tog_q[g] <= 1'b0;
        end else if (!ctrl[g][`PCG_CTRL_TOG_BIT]) begin
          tog_q[g] <= 1'b0; // R9
        end else if (next_raw && !raw_q[g]) begin
          tog_q[g] <= ~tog_q[g]; // R10
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          programmable_control_output[g] <= 1'b0;
        end else if (ctrl[g][`PCG_CTRL_TOG_BIT]) begin
          programmable_control_output[g] <= tog_q[g] ^ ctrl[g][`PCG_CTRL_POL_BIT]; // R9 R8
        end else begin
          programmable_control_output[g] <= raw_q[g] ^ ctrl[g][`PCG_CTRL_POL_BIT]; // R8 R4
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // colour data path
  // ---------------------------------------------------------------------------
  // the data lag equals the control path lag plus the lead, so a channel
  // programmed at count c lines up with data leaving at count c minus the lead
  localparam int LAG = `PCG_DATA_LEAD + 1;
  logic [DATA_W-1:0] data_pipe [LAG];
  logic [LAG-1:0] start_pipe;

  always_ff @(posedge clk_sys) begin
    data_pipe[0] <= data_sync;
    for (int i = 1; i < LAG; i++) begin
      data_pipe[i] <= data_pipe[i-1];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      start_pipe <= '0;
    end else begin
      start_pipe <= {start_pipe[LAG-2:0], line_edge}; // R13
    end
  end

  logic inv_on;
  logic blank_on;
  assign inv_on = out_fmt[`PCG_OUT_FMT_INV_EN_BIT] &&
                  programmable_control_output[`PCG_INV_CHANNEL] == out_fmt[`PCG_OUT_FMT_INV_SENSE_BIT]; // R14
  assign blank_on = in_fmt[`PCG_IN_FMT_BLANK_EN_BIT] && !programmable_control_output[`PCG_BLANK_CHANNEL]; // R15

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      colour_data_out <= '0;
      serial_lane_clock_en <= 1'b0;
      column_start_pulse <= 1'b0;
    end else begin
      // blanking wins over inversion so a blanked lane never shows all ones
      if (blank_on) begin
        colour_data_out <= '0; // R15
      end else if (inv_on) begin
        colour_data_out <= ~data_pipe[LAG-1]; // R14
      end else begin
        colour_data_out <= data_pipe[LAG-1];
      end
      serial_lane_clock_en <= !blank_on; // R15
      column_start_pulse <= start_pipe[LAG-1] && !blank_on; // R15 R13
    end
  end

endmodule : pcg_pulse_gen
`default_nettype wire

/* sim/pcg_pulse_gen_checker.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pcg_map.svh"
// ----
// port checks
// ----
module pcg_pulse_gen_checker #(
  parameter int CHANNELS = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // video and panel side
  input wire logic line_start_pin,
  input wire logic [CHANNELS-1:0] programmable_control_output,
  input wire logic serial_lane_clock_en,
  input wire logic column_start_pulse
);
  logic blank_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // mirror of the blanking enable, taken from the writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      blank_q <= 1'b0;
    end else if (reg_wr && reg_addr == `PCG_ADDR_IN_FMT) begin
      blank_q <= reg_wdata[`PCG_IN_FMT_BLANK_EN_BIT];
    end
  end
  property p_sp_single;
    column_start_pulse |=> !column_start_pulse;
  endproperty
  a_sp_single: assert property (p_sp_single) else $error("start pulse too wide");
  property p_sp_follow;
    $rose(line_start_pin) && !blank_q |-> ##[4:12] column_start_pulse;
  endproperty
  a_sp_follow: assert property (p_sp_follow) else $error("no start pulse after line edge");
  property p_blank;
    (blank_q && !programmable_control_output[9]) [*3] |-> !serial_lane_clock_en && !column_start_pulse;
  endproperty
  a_blank: assert property (p_blank) else $error("blanking not applied");
  property p_ctrl_rb;
    logic [6:0] a;
    logic [15:0] d;
    (reg_wr && reg_addr[2:0] == 3'h4 && reg_addr < 7'h50, a = reg_addr, d = reg_wdata) ##1
      (reg_rd && reg_addr == a) |=> reg_rdata == {8'h00, d[7:0]};
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  property p_unmapped;
    reg_rd && reg_addr > 7'h53 |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hole;
    reg_rd && reg_addr < 7'h50 && reg_addr[2:0] > 3'h4 |=> reg_rdata == 16'h0000;
  endproperty
  a_hole: assert property (p_hole) else $error("unused channel slot not zero");
  property p_timing_w;
    reg_rd && reg_addr < 7'h50 && reg_addr[2:0] < 3'h4 |=> reg_rdata[15:12] == 4'h0;
  endproperty
  a_timing_w: assert property (p_timing_w) else $error("timing value too wide");
  property p_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
endmodule : pcg_pulse_gen_checker

bind pcg_pulse_gen pcg_pulse_gen_checker #(.CHANNELS(CHANNELS)) i_chk (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_start_pin(line_start_pin),
  .programmable_control_output(programmable_control_output),
  .serial_lane_clock_en(serial_lane_clock_en), .column_start_pulse(column_start_pulse));
`default_nettype wire

/* sim/pcg_panel_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----
// panel driver inputs
// ----
module pcg_panel_model (
  // clock and window
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic [3:0] sel,
  // control lines
  input wire logic [9:0] ctrl_in,
  // activity seen
  output logic [11:0] hi_cnt,
  output logic [7:0] chg_cnt
);
  logic prev;
  // drivers only latch levels, so count high cycles and changes
  always_ff @(posedge clk_sys) begin
    prev <= ctrl_in[sel];
    if (clr) begin
      hi_cnt <= 12'h000;
      chg_cnt <= 8'h00;
    end else begin
      hi_cnt <= hi_cnt + 12'(ctrl_in[sel]);
      chg_cnt <= chg_cnt + 8'(ctrl_in[sel] != prev);
    end
  end
endmodule : pcg_panel_model
`default_nettype wire

/* sim/panel_control_pulse_generator_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pcg_map.svh"
module panel_control_pulse_generator_bench;
  localparam int L = 64;
  localparam int F = 512;
  typedef struct {
    int v[5];
    int hi;
    int chg;
  } pcg_row_t;
  // hi of 4095 skips the level count: toggle phase carries over frames
  pcg_row_t rows[7] = '{'{'{0, 0, 0, 0, 0}, 0, 0}, '{'{0, 0, 0, 0, 1}, F, 0},
    '{'{0, 0, 24, 5, 0}, 40, 16}, '{'{2, 3, 24, 0, 0}, 192, 2}, '{'{2, 3, 24, 5, 0}, 15, 6},
    '{'{2, 3, 24, 5, 1}, F - 15, 6}, '{'{1, 3, 24, 4, 2}, 4095, 3}};
  logic clk_sys, rst, reg_wr, reg_rd, clr, lane_en, sp;
  logic line_pin = 1'b0;
  logic frame_pin = 1'b0;
  logic [6:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [17:0] pix, colour;
  logic [9:0] outs;
  logic [11:0] hi_cnt;
  logic [7:0] chg_cnt;
  int tcnt = 0;
  int n, fail_count, compares;

  pcg_pulse_gen i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_start_pin(line_pin),
    .frame_start_pin(frame_pin), .pixel_data_pin(pix), .programmable_control_output(outs),
    .colour_data_out(colour), .serial_lane_clock_en(lane_en), .column_start_pulse(sp));
  pcg_panel_model i_panel (.clk_sys(clk_sys), .clr(clr), .sel(4'h1), .ctrl_in(outs),
    .hi_cnt(hi_cnt), .chg_cnt(chg_cnt));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ----
  // video source: 8 lines of 64 clocks, frame level across line 1 edge
  // ----
  always @(posedge clk_sys) begin
    tcnt <= (tcnt + 1) % F;
    pix <= 18'h0a5a5 ^ 18'((tcnt + 1) % L);
    line_pin <= (tcnt + 1) % L < 4;
    frame_pin <= (tcnt + 9) % F < 16;
  end

  task complete_run;
    $display("mismatches %0d, checks %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task chk(string name, logic [17:0] seen, logic [17:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task stall(logic hit);
    if (hit) begin
      fail_count++;
      complete_run();
    end
  endtask : stall
  task wr(logic [6:0] a, logic [15:0] d);
    if (reg_wr) @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(logic [6:0] a, logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("rdata", 18'(reg_rdata), 18'(e));
    @(posedge clk_sys);
  endtask : rd
  task wait_pos(int p);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (tcnt != p && n < 2 * F);
    stall(n >= 2 * F);
  endtask : wait_pos
  task wait_sp;
    wait_pos(4);
    n = 0;
    while (sp !== 1'b1 && n < L) begin
      @(posedge clk_sys);
      n++;
    end
    stall(n >= L);
  endtask : wait_sp

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
    clr = 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("reset", 18'({outs, lane_en, sp}), 18'h00000);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(7'h04, 16'h0000);
    wr(7'h1b, 16'hffff);
    rd(7'h1b, 16'h0fff);
    wr(7'h0c, 16'h1234);
    rd(7'h0c, 16'h0034);
    rd(7'h0d, 16'h0000);
    rd(7'h55, 16'h0000);
    foreach (rows[i]) begin
      for (int f = 0; f < 5; f++) wr(7'(8 + f), 16'(rows[i].v[f]));
      wait_pos(4);
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
      repeat (F) @(posedge clk_sys);
      #1;
      if (rows[i].hi != 4095) chk("high", 18'(hi_cnt), 18'(rows[i].hi));
      chk("edges", 18'(chg_cnt), 18'(rows[i].chg));
      @(posedge clk_sys);
    end
    wr(7'h12, 16'h0018);
    wr(7'h13, 16'h0003);
    wait_sp();
    n = 0;
    while (outs[2] !== 1'b1 && n < L) begin
      @(posedge clk_sys);
      n++;
    end
    stall(n >= L);
    chk("lead", 18'(n), 18'(24 - `PCG_DATA_LEAD));
    wr(7'h04, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      wr(7'h50, k ? 16'h0008 : 16'h0018);
      wait_sp();
      chk("colour", colour, k ? 18'h0a5a5 : ~18'h0a5a5);
      @(posedge clk_sys);
    end
    // enable mid-line so no start pulse is cut while in flight
    wait_pos(40);
    wr(7'h51, 16'h0040);
    wait_pos(40);
    n = 0;
    repeat (F) begin
      @(posedge clk_sys);
      n += int'(sp === 1'b1 || lane_en !== 1'b0 || colour !== 18'h00000);
    end
    chk("blanked", 18'(n), 18'h00000);
    wr(7'h51, 16'h0000);
    wait_sp();
    chk("lane clock", 18'(lane_en), 18'h00001);
    // second reset in mid run: outputs and registers go back to their reset state
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk("reset again", 18'({outs, lane_en, sp}), 18'h00000);
    chk("reset colour", colour, 18'h00000);
    @(posedge clk_sys);
    rd(7'h0c, 16'h0000);
    rd(7'h51, 16'h0000);
    complete_run();
  end
endmodule : panel_control_pulse_generator_bench
`default_nettype wire
